// ==== hw/free_run_defs.svh ====
`ifndef FREE_RUN_DEFS_SVH
`define FREE_RUN_DEFS_SVH

// map select on the device register port
`define MAP_IO             1'b0
`define MAP_PROC           1'b1

// io map offsets
`define IO_VIDEO_STD       8'h00
`define IO_PRIM_MODE       8'h01
`define IO_OUT_FORMAT      8'h03
`define IO_AV_CODE         8'h05
`define IO_POWER_A         8'h0B
`define IO_POWER_B         8'h0C
`define IO_OUT_DRIVE       8'h15

// component_processor map offsets
`define FR_HDMI_SEL        8'hBA
`define FR_CONTROL         8'hBF
`define FR_COLOUR_A        8'hC0
`define FR_COLOUR_B        8'hC1
`define FR_COLOUR_C        8'hC2
`define FR_BUFFER          8'hC9

// field positions
`define FORCE_BIT          0
`define AUTO_BIT           1
`define MANUAL_BIT         2
`define HDMI_SEL_BIT       0
`define BUF_OFF_BIT        0
`define AV_CODE_BIT        2
`define TRISTATE_BIT       0
`define PDN_A_BIT          0
`define PDN_B_BIT          5

// reset values
`define RST_VIDEO_STD      8'h00
`define RST_PRIM_MODE      8'h00
`define RST_OUT_FORMAT     8'h00
`define RST_AV_CODE        8'h2C
`define RST_POWER_A        8'h47
`define RST_POWER_B        8'h62
`define RST_OUT_DRIVE      8'hBF
`define RST_FR_REG         8'h00

// encodings
`define OUT_FMT_444_SDR    8'h42
`define PRIM_SD_COMP       4'h1
`define PRIM_SD_GFX        4'h2
`define PRIM_GRAPHICS      4'h4
`define PRIM_COMPONENT     4'h5
`define STD_1080I          6'h05
`define STD_VGA_480P       6'h08

// built-in automatic colour (green, red, blue channels)
`define AUTO_COLOUR_A      8'h00
`define AUTO_COLOUR_B      8'h00
`define AUTO_COLOUR_C      8'hFF

// frame timing in pixel clocks and lines
`define VGA_HACT           12'h280
`define VGA_HTOT           12'h320
`define VGA_HFP            12'h010
`define VGA_HSW            12'h060
`define VGA_VACT           12'h1E0
`define VGA_VTOT           12'h20D
`define VGA_VFP            12'h00A
`define VGA_VSW            12'h002
`define I1080_HACT         12'h780
`define I1080_HTOT         12'h898
`define I1080_HFP          12'h058
`define I1080_HSW          12'h02C
`define I1080_VACT         12'h21C
`define I1080_VTOT         12'h465
`define I1080_VFP          12'h002
`define I1080_VSW          12'h005
`define P480_HACT          12'h2D0
`define P480_HTOT          12'h35A
`define P480_HFP           12'h010
`define P480_HSW           12'h03E
`define P480_VACT          12'h1E0
`define P480_VTOT          12'h20D
`define P480_VFP           12'h009
`define P480_VSW           12'h006
`define CODE_LEN           12'h004

// host wishbone offsets
`define HOST_CMD           8'h00
`define HOST_GO            8'h04
`define HOST_STATUS        8'h08
`define HOST_LINE_PIX      8'h0C
`define HOST_FRAME_LINES   8'h10
`define HOST_COLOUR        8'h14

`endif

// ==== hw/free_run_pkg.sv ====
package free_run_pkg;

   typedef enum logic [1:0] {FMT_VGA60, FMT_1080I60, FMT_480P60} frame_fmt_t;

   typedef struct packed {
      logic [11:0] hact;
      logic [11:0] htot;
      logic [11:0] hfp;
      logic [11:0] hsw;
      logic [11:0] vact;
      logic [11:0] vtot;
      logic [11:0] vfp;
      logic [11:0] vsw;
      logic        interlaced;
   } frame_timing_t;

   typedef struct packed {
      logic       free_run;
      frame_fmt_t fmt;
      logic [7:0] col_a;
      logic [7:0] col_b;
      logic [7:0] col_c;
   } frame_cfg_t;

   typedef enum logic {HOST_IDLE, HOST_WAIT} host_state_t;

endpackage

// ==== hw/free_run_if.sv ====
`timescale 1ns/10ps
interface free_run_if;
   // register port
   logic        reg_req;
   logic        reg_we;
   logic        reg_map;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_ack;
   logic [7:0]  reg_rdata;
   // output pixel bus
   logic [35:0] pix_data;
   logic        pix_oe;
   logic        hsync;
   logic        vsync;
   logic        de;
   logic        field;

   modport device (
      input  reg_req, reg_we, reg_map, reg_addr, reg_wdata,
      output reg_ack, reg_rdata,
      output pix_data, pix_oe, hsync, vsync, de, field
   );

   modport host (
      output reg_req, reg_we, reg_map, reg_addr, reg_wdata,
      input  reg_ack, reg_rdata,
      input  pix_data, pix_oe, hsync, vsync, de, field
   );
endinterface

// ==== hw/free_run_device.sv ====
// Behaviour
// [RQ1] force bit replaces input video by free-run
// [RQ2] flat colour frame, 8-bit MSB-aligned, with syncs
// [RQ3] manual bit takes colour from channel registers
// [RQ4] format from video standard and primary mode
// [RQ5] hdmi: mode 4, standard 8 gives 640x480p60
// [RQ6] hdmi: mode 5, standard 5 gives 1080i60
// [RQ7] non-hdmi: 1/5 gives 1080i60, 2/8 480p
// [RQ8] channel a green, b red, c blue
// [RQ9] host selects hdmi free-run via 0xBA
// [RQ10] host writes 0x17 to control register
// [RQ11] buffer register stops automatic parameter buffering
// [RQ12] host releases bus tristate via 0x15
// [RQ13] host powers part up via 0x0B, 0x0C
// [RQ14] 0x42 in 0x03 selects 36-bit 444 SDR
// [RQ15] 0x28 in 0x05 suppresses timing codes
// [RQ16] auto bit gives built-in default colour
// [RQ17] setting changes apply at frame boundary
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "free_run_defs.svh"
module free_run_device
   import free_run_pkg::*;
#(
   parameter bit HDMI_INPUT = 1'b1
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // register port and pixel bus
   free_run_if.device       bus,
   // incoming video
   input  wire logic [35:0] in_pix_data,
   input  wire logic        in_hsync,
   input  wire logic        in_vsync,
   input  wire logic        in_de,
   input  wire logic        in_field,
   // status
   output logic             free_run_active
);

   logic [7:0]    std_ff, prim_ff, out_fmt_ff, av_ff;
   logic [7:0]    pwr_a_ff, pwr_b_ff, drive_ff;
   logic [7:0]    hdmi_sel_ff, ctrl_ff, buf_ff;
   logic [7:0]    col_a_ff, col_b_ff, col_c_ff;
   logic          ack_ff;
   logic [7:0]    rdata_ff;
   logic [7:0]    rd_val;
   logic          wr;
   logic          pend_ff;
   logic          powered;
   logic          load;
   frame_cfg_t    cfg_ff;
   frame_cfg_t    nxt_cfg;
   frame_timing_t tm;
   logic [11:0]   h_ff, v_ff;
   logic [11:0]   h_last, v_last, half, lif;
   logic [11:0]   hs_beg, hs_end, vs_beg, vs_end, code_beg;
   logic          frame_end, fld, h_act, v_act, hs, vs, in_code;
   logic [7:0]    code_word;
   logic [35:0]   gen_pix;
   logic [35:0]   pix_ff;
   logic          hs_ff, vs_ff, de_ff, fld_ff;

   // register port: one-cycle answer
   assign wr = bus.reg_req & bus.reg_we & ~ack_ff;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 8'h00;
      end else begin
         ack_ff   <= bus.reg_req & ~ack_ff;
         if (bus.reg_req & ~ack_ff) begin
            rdata_ff <= rd_val;
         end
      end
   end

   assign bus.reg_ack   = ack_ff;
   assign bus.reg_rdata = rdata_ff;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         std_ff      <= `RST_VIDEO_STD;
         prim_ff     <= `RST_PRIM_MODE;
         out_fmt_ff  <= `RST_OUT_FORMAT;
         av_ff       <= `RST_AV_CODE;
         pwr_a_ff    <= `RST_POWER_A;
         pwr_b_ff    <= `RST_POWER_B;
         drive_ff    <= `RST_OUT_DRIVE;
         hdmi_sel_ff <= `RST_FR_REG;
         ctrl_ff     <= `RST_FR_REG;
         col_a_ff    <= `RST_FR_REG;
         col_b_ff    <= `RST_FR_REG;
         col_c_ff    <= `RST_FR_REG;
         buf_ff      <= `RST_FR_REG;
      end else if (wr && bus.reg_map == `MAP_IO) begin
         unique case (bus.reg_addr)
            `IO_VIDEO_STD:  std_ff     <= bus.reg_wdata;
            `IO_PRIM_MODE:  prim_ff    <= bus.reg_wdata;
            `IO_OUT_FORMAT: out_fmt_ff <= bus.reg_wdata;
            `IO_AV_CODE:    av_ff      <= bus.reg_wdata;
            `IO_POWER_A:    pwr_a_ff   <= bus.reg_wdata;
            `IO_POWER_B:    pwr_b_ff   <= bus.reg_wdata;
            `IO_OUT_DRIVE:  drive_ff   <= bus.reg_wdata;
            default: ;
         endcase
      end else if (wr) begin
         unique case (bus.reg_addr)
            `FR_HDMI_SEL: hdmi_sel_ff <= bus.reg_wdata;
            `FR_CONTROL:  ctrl_ff     <= bus.reg_wdata;
            `FR_COLOUR_A: col_a_ff    <= bus.reg_wdata;
            `FR_COLOUR_B: col_b_ff    <= bus.reg_wdata;
            `FR_COLOUR_C: col_c_ff    <= bus.reg_wdata;
            `FR_BUFFER:   buf_ff      <= bus.reg_wdata;
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_val = 8'h00;
      if (bus.reg_map == `MAP_IO) begin
         unique case (bus.reg_addr)
            `IO_VIDEO_STD:  rd_val = std_ff;
            `IO_PRIM_MODE:  rd_val = prim_ff;
            `IO_OUT_FORMAT: rd_val = out_fmt_ff;
            `IO_AV_CODE:    rd_val = av_ff;
            `IO_POWER_A:    rd_val = pwr_a_ff;
            `IO_POWER_B:    rd_val = pwr_b_ff;
            `IO_OUT_DRIVE:  rd_val = drive_ff;
            default:        rd_val = 8'h00;
         endcase
      end else begin
         unique case (bus.reg_addr)
            `FR_HDMI_SEL: rd_val = hdmi_sel_ff;
            `FR_CONTROL:  rd_val = ctrl_ff;
            `FR_COLOUR_A: rd_val = col_a_ff;
            `FR_COLOUR_B: rd_val = col_b_ff;
            `FR_COLOUR_C: rd_val = col_c_ff;
            `FR_BUFFER:   rd_val = buf_ff;
            default:      rd_val = 8'h00;
         endcase
      end
   end

   // frame format from primary mode and standard
   function automatic frame_fmt_t decode_fmt(input logic [3:0] prim,
                                             input logic [5:0] std);
      frame_fmt_t f;
      f = HDMI_INPUT ? FMT_VGA60 : FMT_480P60;
      if (HDMI_INPUT) begin
         if (prim == `PRIM_GRAPHICS && std == `STD_VGA_480P)
            f = FMT_VGA60; // RQ5
         if (prim == `PRIM_COMPONENT && std == `STD_1080I)
            f = FMT_1080I60; // RQ6
      end else begin
         if (prim == `PRIM_SD_COMP && std == `STD_1080I)
            f = FMT_1080I60; // RQ7
         if (prim == `PRIM_SD_GFX && std == `STD_VGA_480P)
            f = FMT_480P60; // RQ7
      end
      return f;
   endfunction

   // pending parameter change, set wins over the load
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pend_ff <= 1'b0;
      end else begin
         pend_ff <= wr | (pend_ff & ~load);
      end
   end

   assign powered = ~pwr_a_ff[`PDN_A_BIT] & ~pwr_b_ff[`PDN_B_BIT];
   // buffer off: reload only after a register write
   assign load = (frame_end | ~powered) &
                 (~buf_ff[`BUF_OFF_BIT] | pend_ff); // RQ11 RQ17

   always_comb begin
      nxt_cfg.free_run = ctrl_ff[`FORCE_BIT] &
                         (~HDMI_INPUT | hdmi_sel_ff[`HDMI_SEL_BIT]); // RQ1
      nxt_cfg.fmt = decode_fmt(prim_ff[3:0], std_ff[5:0]); // RQ4
      if (ctrl_ff[`MANUAL_BIT]) begin
         nxt_cfg.col_a = col_a_ff; // RQ3
         nxt_cfg.col_b = col_b_ff;
         nxt_cfg.col_c = col_c_ff;
      end else if (ctrl_ff[`AUTO_BIT]) begin
         nxt_cfg.col_a = `AUTO_COLOUR_A; // RQ16
         nxt_cfg.col_b = `AUTO_COLOUR_B;
         nxt_cfg.col_c = `AUTO_COLOUR_C;
      end else begin
         nxt_cfg.col_a = 8'h00;
         nxt_cfg.col_b = 8'h00;
         nxt_cfg.col_c = 8'h00;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_ff <= '0;
      end else if (load) begin
         cfg_ff <= nxt_cfg; // RQ17
      end
   end

   assign free_run_active = cfg_ff.free_run;

   // timing of the running format
   always_comb begin
      unique case (cfg_ff.fmt)
         FMT_1080I60: tm = '{`I1080_HACT, `I1080_HTOT, `I1080_HFP,
                             `I1080_HSW, `I1080_VACT, `I1080_VTOT,
                             `I1080_VFP, `I1080_VSW, 1'b1};
         FMT_480P60:  tm = '{`P480_HACT, `P480_HTOT, `P480_HFP,
                             `P480_HSW, `P480_VACT, `P480_VTOT,
                             `P480_VFP, `P480_VSW, 1'b0};
         default:     tm = '{`VGA_HACT, `VGA_HTOT, `VGA_HFP,
                             `VGA_HSW, `VGA_VACT, `VGA_VTOT,
                             `VGA_VFP, `VGA_VSW, 1'b0};
      endcase
   end

   assign h_last    = 12'(tm.htot - 12'h001);
   assign v_last    = 12'(tm.vtot - 12'h001);
   assign frame_end = (h_ff == h_last) && (v_ff == v_last);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         h_ff <= 12'h000;
         v_ff <= 12'h000;
      end else if (~powered || h_ff == h_last) begin
         h_ff <= 12'h000;
         v_ff <= (~powered || v_ff == v_last) ? 12'h000 :
                 12'(v_ff + 12'h001);
      end else begin
         h_ff <= 12'(h_ff + 12'h001);
      end
   end

   // two fields per frame when interlaced
   assign half     = tm.interlaced ? {1'b0, tm.vtot[11:1]} : tm.vtot;
   assign fld      = tm.interlaced && (v_ff >= half);
   assign lif      = fld ? 12'(v_ff - half) : v_ff;
   assign hs_beg   = 12'(tm.hact + tm.hfp);
   assign hs_end   = 12'(hs_beg + tm.hsw);
   assign vs_beg   = 12'(tm.vact + tm.vfp);
   assign vs_end   = 12'(vs_beg + tm.vsw);
   assign code_beg = 12'(tm.htot - `CODE_LEN);
   assign h_act    = h_ff < tm.hact;
   assign v_act    = lif < tm.vact;
   assign hs       = (h_ff >= hs_beg) && (h_ff < hs_end);
   assign vs       = (lif >= vs_beg) && (lif < vs_end);
   assign in_code  = (h_ff >= code_beg) &&
                     av_ff[`AV_CODE_BIT]; // RQ15

   always_comb begin
      unique case (h_ff[1:0] - code_beg[1:0])
         2'd0:    code_word = 8'hFF;
         2'd3:    code_word = {1'b1, fld, ~v_act, 5'h00};
         default: code_word = 8'h00;
      endcase
   end

   // channels a, b, c carry green, red, blue, msb-aligned
   always_comb begin
      gen_pix = '0;
      if (h_act && v_act) begin
         gen_pix = {cfg_ff.col_a, 4'h0, cfg_ff.col_b, 4'h0,
                    cfg_ff.col_c, 4'h0}; // RQ2 RQ8
      end else if (in_code) begin
         gen_pix = {3{code_word, 4'h0}};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pix_ff <= '0;
         hs_ff  <= 1'b0;
         vs_ff  <= 1'b0;
         de_ff  <= 1'b0;
         fld_ff <= 1'b0;
      end else if (out_fmt_ff != `OUT_FMT_444_SDR) begin
         pix_ff <= '0; // RQ14
         hs_ff  <= 1'b0;
         vs_ff  <= 1'b0;
         de_ff  <= 1'b0;
         fld_ff <= 1'b0;
      end else if (cfg_ff.free_run) begin
         pix_ff <= gen_pix; // RQ1 RQ2
         hs_ff  <= hs;
         vs_ff  <= vs;
         de_ff  <= h_act && v_act;
         fld_ff <= fld;
      end else begin
         pix_ff <= in_pix_data;
         hs_ff  <= in_hsync;
         vs_ff  <= in_vsync;
         de_ff  <= in_de;
         fld_ff <= in_field;
      end
   end

   assign bus.pix_data = pix_ff;
   assign bus.hsync    = hs_ff;
   assign bus.vsync    = vs_ff;
   assign bus.de       = de_ff;
   assign bus.field    = fld_ff;
   assign bus.pix_oe   = powered & ~drive_ff[`TRISTATE_BIT];

endmodule

// ==== hw/free_run_host.sv ====
`timescale 1ns/10ps
`include "free_run_defs.svh"
module free_run_host
   import free_run_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // wishbone slave
   input  wire logic        wb_cyc,
   input  wire logic        wb_stb,
   input  wire logic        wb_we,
   input  wire logic [7:0]  wb_adr,
   input  wire logic [3:0]  wb_sel,
   input  wire logic [31:0] wb_dat_w,
   output logic [31:0]      wb_dat_r,
   output logic             wb_ack,
   // device side
   free_run_if.host         bus
);

   host_state_t state_ff;
   logic        ack_ff;
   logic [31:0] dat_r_ff;
   logic [31:0] rd_val;
   logic        wb_wr, go;
   logic [7:0]  cmd_addr_ff, cmd_data_ff, rd_byte_ff;
   logic        cmd_map_ff, cmd_we_ff;
   logic        req_ff;
   logic [11:0] pix_cnt_ff, line_cnt_ff, line_pix_ff, frame_lines_ff;
   logic [23:0] colour_ff;
   logic        de_q_ff, vs_q_ff;
   logic        de_in;

   assign wb_wr  = wb_cyc & wb_stb & wb_we & ack_ff;
   assign go     = wb_wr && wb_adr == `HOST_GO && wb_sel[0] && wb_dat_w[0];
   assign wb_ack = ack_ff;
   assign wb_dat_r = dat_r_ff;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_ff   <= 1'b0;
         dat_r_ff <= 32'h0000_0000;
      end else begin
         ack_ff   <= wb_cyc & wb_stb & ~ack_ff;
         if (wb_cyc & wb_stb & ~ack_ff & ~wb_we) begin
            dat_r_ff <= rd_val;
         end
      end
   end

   always_comb begin
      unique case (wb_adr)
         `HOST_CMD:         rd_val = {7'h00, cmd_we_ff, 7'h00, cmd_map_ff,
                                      cmd_data_ff, cmd_addr_ff};
         `HOST_STATUS:      rd_val = {16'h0000, rd_byte_ff, 7'h00,
                                      state_ff == HOST_WAIT};
         `HOST_LINE_PIX:    rd_val = {20'h0_0000, line_pix_ff};
         `HOST_FRAME_LINES: rd_val = {20'h0_0000, frame_lines_ff};
         `HOST_COLOUR:      rd_val = {8'h00, colour_ff};
         default:           rd_val = 32'h0000_0000;
      endcase
   end

   // command register, byte lanes per field
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_addr_ff <= 8'h00;
         cmd_data_ff <= 8'h00;
         cmd_map_ff  <= 1'b0;
         cmd_we_ff   <= 1'b0;
      end else if (wb_wr && wb_adr == `HOST_CMD) begin
         if (wb_sel[0]) cmd_addr_ff <= wb_dat_w[7:0];
         if (wb_sel[1]) cmd_data_ff <= wb_dat_w[15:8];
         if (wb_sel[2]) cmd_map_ff  <= wb_dat_w[16];
         if (wb_sel[3]) cmd_we_ff   <= wb_dat_w[24];
      end
   end

   // device register access; holds the request until acknowledged
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff   <= HOST_IDLE;
         req_ff     <= 1'b0;
         rd_byte_ff <= 8'h00;
      end else begin
         unique case (state_ff)
            HOST_IDLE: begin
               if (go) begin
                  state_ff <= HOST_WAIT; // RQ9 RQ10 RQ12 RQ13
                  req_ff   <= 1'b1;
               end
            end
            HOST_WAIT: begin
               if (bus.reg_ack) begin
                  state_ff   <= HOST_IDLE;
                  req_ff     <= 1'b0;
                  rd_byte_ff <= bus.reg_rdata;
               end
            end
         endcase
      end
   end

   assign bus.reg_req   = req_ff;
   assign bus.reg_we    = cmd_we_ff;
   assign bus.reg_map   = cmd_map_ff;
   assign bus.reg_addr  = cmd_addr_ff;
   assign bus.reg_wdata = cmd_data_ff;

   // downstream measurement of the pixel bus
   assign de_in = bus.de & bus.pix_oe;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         de_q_ff        <= 1'b0;
         vs_q_ff        <= 1'b0;
         pix_cnt_ff     <= 12'h000;
         line_cnt_ff    <= 12'h000;
         line_pix_ff    <= 12'h000;
         frame_lines_ff <= 12'h000;
         colour_ff      <= 24'h00_0000;
      end else begin
         de_q_ff <= de_in;
         vs_q_ff <= bus.vsync & bus.pix_oe;
         if (de_in) begin
            pix_cnt_ff <= 12'(pix_cnt_ff + 12'h001);
            colour_ff  <= {bus.pix_data[35:28], bus.pix_data[23:16],
                           bus.pix_data[11:4]};
         end else if (de_q_ff) begin
            pix_cnt_ff  <= 12'h000;
            line_pix_ff <= pix_cnt_ff;
         end
         if (bus.vsync & bus.pix_oe & ~vs_q_ff) begin
            frame_lines_ff <= line_cnt_ff;
            line_cnt_ff    <= 12'h000;
         end else if (~de_in & de_q_ff) begin
            line_cnt_ff <= 12'(line_cnt_ff + 12'h001);
         end
      end
   end

endmodule

// ==== bench/free_run_props.sv ====
`timescale 1ns/10ps
module free_run_props (
   // clock and reset
   input wire logic        clk,
   input wire logic        sys_rst,
   // watched signals
   input wire logic        reg_req,
   input wire logic        reg_we,
   input wire logic        reg_ack,
   input wire logic [7:0]  reg_rdata,
   input wire logic [35:0] pix_data,
   input wire logic        pix_oe,
   input wire logic        hsync,
   input wire logic        vsync,
   input wire logic        de,
   input wire logic        free_run_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [11:0] run_ff;
   logic [11:0] hs_ff;
   logic [11:0] de_ff;
   logic        steady;
   // steady once free-run has driven the bus for more than a line
   assign steady = run_ff == 12'hFFF;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) run_ff <= 12'h000;
      else if (!(free_run_active && pix_oe)) run_ff <= 12'h000;
      else if (!steady) run_ff <= run_ff + 12'h001;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) hs_ff <= 12'h000;
      else hs_ff <= hsync ? hs_ff + 12'h001 : 12'h000;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) de_ff <= 12'h000;
      else de_ff <= de ? de_ff + 12'h001 : 12'h000;
   end
   property p_ack_pulse;
      reg_ack |=> !reg_ack;
   endproperty
   property p_ack_follows;
      reg_req && !reg_ack |=> reg_ack;
   endproperty
   property p_rdata_hold;
      !reg_ack |-> $stable(reg_rdata);
   endproperty
   property p_nibble;
      steady && de |-> pix_data[27:24] == 4'h0 && pix_data[15:12] == 4'h0
         && pix_data[3:0] == 4'h0;
   endproperty
   property p_flat;
      steady && de && $past(de) |-> $stable(pix_data);
   endproperty
   property p_de_sync;
      steady && de |-> !hsync && !vsync;
   endproperty
   property p_hs_width;
      steady && $fell(hsync) |-> hs_ff inside {12'h060, 12'h02C, 12'h03E};
   endproperty
   property p_de_len;
      steady && $fell(de) |-> de_ff inside {12'h280, 12'h780, 12'h2D0};
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("register ack longer than one cycle");
   a_ack_follows: assert property (p_ack_follows)
      else $error("register request not acked next cycle");
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read byte changed without ack");
   a_nibble: assert property (p_nibble)
      else $error("low nibble of a channel not zero");
   a_flat: assert property (p_flat)
      else $error("colour changed within a line");
   a_de_sync: assert property (p_de_sync)
      else $error("sync active during active video");
   a_hs_width: assert property (p_hs_width)
      else $error("hsync width wrong");
   a_de_len: assert property (p_de_len)
      else $error("active line length wrong");
   c_write: cover property (reg_ack && reg_we);
   c_read: cover property (reg_ack && !reg_we);
   c_line: cover property (steady && $fell(de));
endmodule

// ==== bench/free_run_video_pattern_output_tb.sv ====
`timescale 1ns/10ps
`include "free_run_defs.svh"
module free_run_video_pattern_output_tb
   import free_run_pkg::*;
;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [3:0]  wb_sel = 4'h0;
   logic [31:0] wb_dat_w = 32'h0000_0000, wb_dat_r, rd;
   logic        wb_ack, free_run_active;
   logic [35:0] in_pix_data = 36'h0_0000_0000, prev;
   logic        in_hsync = 1'b0, in_vsync = 1'b0;
   logic        in_de = 1'b0, in_field = 1'b0;
   logic [7:0]  q, ca, cb, cc, st, pm, ct;
   int          errors = 0, checks_done = 0, cycles = 0;
   logic [16:0] rst_tab [8] = '{17'h0_052C, 17'h0_0B47, 17'h0_0C62,
      17'h0_15BF, 17'h1_BF00, 17'h1_C900, 17'h1_5000, 17'h0_0300};
   logic [31:0] fmt_tab [4] = '{32'h0804_1700, 32'h0505_0300,
      32'h1E05_0700, 32'h0804_0100};

   always #5 clk = ~clk;
   always @(posedge clk) begin
      in_pix_data <= 36'({$urandom(), $urandom()});
      {in_hsync, in_vsync, in_de, in_field} <= 4'($urandom());
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 100000) begin
         errors++;
         wrap_up();
      end
   end

   free_run_if i_free_run_if ();
   free_run_device i_free_run_device (
      .clk(clk), .sys_rst(sys_rst), .bus(i_free_run_if),
      .in_pix_data(in_pix_data), .in_hsync(in_hsync),
      .in_vsync(in_vsync), .in_de(in_de), .in_field(in_field),
      .free_run_active(free_run_active));
   free_run_host i_free_run_host (
      .clk(clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
      .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
      .bus(i_free_run_if));
   free_run_props i_free_run_props (
      .clk(clk), .sys_rst(sys_rst),
      .reg_req(i_free_run_if.reg_req), .reg_we(i_free_run_if.reg_we),
      .reg_ack(i_free_run_if.reg_ack),
      .reg_rdata(i_free_run_if.reg_rdata),
      .pix_data(i_free_run_if.pix_data), .pix_oe(i_free_run_if.pix_oe),
      .hsync(i_free_run_if.hsync), .vsync(i_free_run_if.vsync),
      .de(i_free_run_if.de), .free_run_active(free_run_active));

   function automatic logic [11:0] exp_hact(logic [7:0] s, p);
      if (p[3:0] == 4'h5 && s[5:0] == 6'h05) return 12'h780;
      return 12'h280;
   endfunction
   function automatic logic [23:0] exp_col(logic [7:0] c, a, b, d);
      if (c[2]) return {a, b, d};
      if (c[1]) return 24'h00_00FF;
      return 24'h00_0000;
   endfunction
   task automatic chk(input string nm, input logic [35:0] e, g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_sel <= 4'hF;
      wb_dat_w <= d;
      do @(posedge clk); while (wb_ack !== 1'b1);
      rd = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   task automatic dev(input logic w, m, input logic [7:0] a, d);
      wb(1'b1, `HOST_CMD, {7'h00, w, 7'h00, m, d, a});
      wb(1'b1, `HOST_GO, 32'h0000_0001);
      do wb(1'b0, `HOST_STATUS, 32'h0000_0000); while (rd[0] !== 1'b0);
      q = rd[15:8];
   endtask
   task automatic io(input logic [7:0] a, d);
      dev(1'b1, 1'b0, a, d);
   endtask
   task automatic pr(input logic [7:0] a, d);
      dev(1'b1, 1'b1, a, d);
   endtask
   task automatic wrap_up;
      if (errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      void'($urandom(23709));
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      chk("pix_oe", 36'h0, 36'(i_free_run_if.pix_oe));
      foreach (rst_tab[i]) begin
         dev(1'b0, rst_tab[i][16], rst_tab[i][15:8], 8'h00);
         chk("reset value", 36'(rst_tab[i][7:0]), 36'(q));
      end
      wb(1'b0, 8'hF0, 32'h0000_0000);
      chk("unmapped", 36'h0, 36'(rd));
      for (int i = 0; i < 3; i++) begin
         ca = 8'($urandom());
         pr(8'hC0 + 8'(i), ca);
         dev(1'b0, 1'b1, 8'hC0 + 8'(i), 8'h00);
         chk("colour reg", 36'(ca), 36'(q));
      end
      io(8'h0B, 8'h44);
      io(8'h0C, 8'h42);
      io(8'h15, 8'h80);
      io(8'h05, 8'h28);
      @(negedge clk);
      chk("pix_oe", 36'h1, 36'(i_free_run_if.pix_oe));
      chk("bus format", 36'h0, i_free_run_if.pix_data);
      io(8'h03, 8'h42);
      repeat (4) begin
         @(negedge clk) prev = in_pix_data;
         @(negedge clk) chk("pass", prev, i_free_run_if.pix_data);
      end
      pr(8'hBA, 8'h01);
      pr(8'hC9, 8'h05);
      foreach (fmt_tab[i]) begin
         {st, pm, ct} = fmt_tab[i][31:8];
         ca = 8'($urandom());
         cb = 8'($urandom());
         cc = 8'($urandom());
         io(8'h0C, 8'h62);
         io(8'h00, st);
         io(8'h01, pm);
         pr(8'hBF, ct);
         pr(8'hC0, ca);
         pr(8'hC1, cb);
         pr(8'hC2, cc);
         io(8'h0C, 8'h42);
         repeat (7000) @(posedge clk);
         chk("free run", 36'h1, 36'(free_run_active));
         wb(1'b0, `HOST_LINE_PIX, 32'h0000_0000);
         chk("line", 36'(exp_hact(st, pm)), 36'(rd[11:0]));
         wb(1'b0, `HOST_COLOUR, 32'h0000_0000);
         chk("colour", 36'(exp_col(ct, ca, cb, cc)), 36'(rd[23:0]));
         pr(8'hBF, 8'h00);
         repeat (2500) @(posedge clk);
         wb(1'b0, `HOST_COLOUR, 32'h0000_0000);
         chk("held", 36'(exp_col(ct, ca, cb, cc)), 36'(rd[23:0]));
      end
      wrap_up();
   end
endmodule
